// >>> src/fan_tach_speed_monitor.sv
`timescale 1ns/1ps
// Operation
// RL1 - limit register read B1, write B8
// RL2 - flag status when period exceeds limit
// RL3 - divide internal clock to 8415 Hz
// RL4 - full-scale reference is 8415 over divider
// RL5 - software keeps prescaled tach 33-66 Hz
// RL6 - current step makes one internal pulse
// RL7 - current-sense pulse rate is tach times P/(P-1)
// RL8 - software sets divider for current-sense mode
// RL9 - software sets limit from fan-fail ratio
// RL10 - no prescale of one in current-sense; code still divides by 1 at prescale select 0 with cur_sense set
// RL11 - count timebase ticks between speed pulses
// RL12 - counter overflow ORs into fail bit
// RL13 - prescale codes divide by 1,2,4,8
// RL14 - divider floors at 127, resets to 255
// RL15 - frame is command byte plus data byte
module fan_tach_speed_monitor #(
  parameter int TB_DIV = fan_tach_pkg::TIMEBASE_DIV
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // serial port
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic sdin,
  output logic      sdout,
  // fan feedback
  input  wire logic tach_in,
  input  wire logic current_step,
  // regulation loop
  output logic      ref_pulse,
  output logic      speed_pulse,
  output logic      fan_fail
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } meas_state_t;

  logic                  rst_s1_q, rst_s2_q;
  logic [2:0]            pin_s1_q, pin_s2_q;
  logic [1:0]            fb_s1_q, fb_s2_q;
  fan_tach_pkg::spi_in_t pins;
  fan_tach_pkg::cfg_t    cfg_q;
  logic [7:0]            cmd, wr_data, rd_data, period_q, period_cnt_q;
  logic                  cmd_valid, wr_strobe, tb_tick, raw_pulse;
  logic [31:0]           tb_cnt_q;
  logic [7:0]            fs_cnt_q, fs_eff;
  logic [2:0]            pre_cnt_q;
  logic [2:0]            pre_max;
  logic                  fail_q, ovf_q, fb_d1_q;
  meas_state_t           state_q;

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      pin_s1_q <= 3'h2;
      pin_s2_q <= 3'h2;
      fb_s1_q  <= 2'h0;
      fb_s2_q  <= 2'h0;
    end else if (clk_en) begin
      pin_s1_q <= {sclk, cs_n, sdin};
      pin_s2_q <= pin_s1_q;
      fb_s1_q  <= {tach_in, current_step};
      fb_s2_q  <= fb_s1_q;
    end
  end

  assign pins = '{sclk: pin_s2_q[2], cs_n: pin_s2_q[1], sdin: pin_s2_q[0]};

  ////////////////////////////////////////////////////////////////////////
  // serial port
  fan_spi_slave u_spi (
    .ref_clk   (ref_clk),
    .rst_n     (rst_s2_q),
    .clk_en    (clk_en),
    .pins      (pins),
    .rd_data   (rd_data),
    .cmd_q     (cmd),
    .cmd_valid (cmd_valid),
    .wr_data   (wr_data),
    .wr_strobe (wr_strobe),
    .sdout     (sdout)
  );

  always_comb begin
    if (cmd == fan_tach_pkg::CMD_RD_LIMIT) begin
      rd_data = cfg_q.limit; // RL1
    end else if (cmd == fan_tach_pkg::CMD_RD_FULLSCALE) begin
      rd_data = cfg_q.full_scale_divider;
    end else if (cmd == fan_tach_pkg::CMD_RD_PRESCALE) begin
      rd_data = {6'h00, cfg_q.tach_prescale_select};
    end else if (cmd == fan_tach_pkg::CMD_RD_PERIOD) begin
      rd_data = period_q;
    end else if (cmd == fan_tach_pkg::CMD_RD_STATUS) begin
      rd_data = {7'h00, fail_q};
    end else if (cmd == fan_tach_pkg::CMD_RD_CONTROL) begin
      rd_data = {6'h00, cfg_q.cur_sense, 1'b0};
    end else begin
      rd_data = 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      cfg_q.limit                <= fan_tach_pkg::LIMIT_RST;
      cfg_q.full_scale_divider   <= fan_tach_pkg::FULLSCALE_RST; // RL14
      cfg_q.tach_prescale_select <= fan_tach_pkg::PRESCALE_RST;
      cfg_q.cur_sense            <= 1'b0;
    end else if (clk_en && wr_strobe && cmd_valid) begin // RL15
      if (cmd == fan_tach_pkg::CMD_WR_LIMIT) begin
        cfg_q.limit <= wr_data; // RL1
      end else if (cmd == fan_tach_pkg::CMD_WR_FULLSCALE) begin
        cfg_q.full_scale_divider <= wr_data;
      end else if (cmd == fan_tach_pkg::CMD_WR_PRESCALE) begin
        cfg_q.tach_prescale_select <= wr_data[1:0];
      end else if (cmd == fan_tach_pkg::CMD_WR_CONTROL) begin
        cfg_q.cur_sense <= wr_data[fan_tach_pkg::CTRL_CURSENSE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timebase and full-scale reference
  assign tb_tick = (tb_cnt_q == 32'(TB_DIV - 1)); // RL3

  always_ff @(posedge ref_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      tb_cnt_q <= 32'h0000_0000;
    end else if (clk_en) begin
      tb_cnt_q <= tb_tick ? 32'h0000_0000 : tb_cnt_q + 32'h0000_0001; // RL3
    end
  end

  assign fs_eff = (cfg_q.full_scale_divider < fan_tach_pkg::FULLSCALE_MIN) ?
                  fan_tach_pkg::FULLSCALE_MIN : cfg_q.full_scale_divider; // RL14

  always_ff @(posedge ref_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      fs_cnt_q  <= 8'h00;
      ref_pulse <= 1'b0;
    end else if (clk_en) begin
      ref_pulse <= 1'b0;
      if (tb_tick) begin
        if (fs_cnt_q >= fs_eff - 8'h01) begin
          fs_cnt_q  <= 8'h00;
          ref_pulse <= 1'b1; // RL4
        end else begin
          fs_cnt_q <= fs_cnt_q + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // feedback source and prescaler
  // current-sense edges give one pulse per rising step
  assign raw_pulse = (cfg_q.cur_sense ? fb_s2_q[0] : fb_s2_q[1]) & ~fb_d1_q; // RL6
  assign pre_max = 3'((4'h1 << cfg_q.tach_prescale_select) - 4'h1); // RL13

  always_ff @(posedge ref_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      fb_d1_q     <= 1'b0;
      pre_cnt_q   <= 3'h0;
      speed_pulse <= 1'b0;
    end else if (clk_en) begin
      fb_d1_q     <= cfg_q.cur_sense ? fb_s2_q[0] : fb_s2_q[1];
      speed_pulse <= 1'b0;
      if (raw_pulse) begin
        if (pre_cnt_q >= pre_max) begin
          pre_cnt_q   <= 3'h0;
          speed_pulse <= 1'b1; // RL13
        end else begin
          pre_cnt_q <= pre_cnt_q + 3'h1; // RL7
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // period measurement and failure flag
  always_ff @(posedge ref_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      state_q      <= ST_IDLE;
      period_cnt_q <= 8'h00;
      period_q     <= 8'h00;
      ovf_q        <= 1'b0;
    end else if (clk_en) begin
      case (state_q)
        ST_IDLE: begin
          if (speed_pulse) begin
            state_q      <= ST_RUN;
            period_cnt_q <= 8'h00;
          end
        end
        ST_RUN: begin
          if (speed_pulse) begin
            period_q     <= period_cnt_q; // RL11
            period_cnt_q <= 8'h00;
            ovf_q        <= 1'b0;
          end else if (tb_tick) begin
            if (period_cnt_q == 8'hFF) begin
              ovf_q <= 1'b1; // RL12
            end else begin
              period_cnt_q <= period_cnt_q + 8'h01; // RL11
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      fail_q <= 1'b0;
    end else if (clk_en) begin
      fail_q <= (period_q > cfg_q.limit) | ovf_q; // RL2 RL12
    end
  end

  assign fan_fail = fail_q;
endmodule

// >>> src/fan_tach_pkg.sv
package fan_tach_pkg;
  // serial command codes
  localparam logic [7:0] CMD_RD_LIMIT     = 8'hB1;
  localparam logic [7:0] CMD_WR_LIMIT     = 8'hB8;
  localparam logic [7:0] CMD_RD_FULLSCALE = 8'hBF;
  localparam logic [7:0] CMD_WR_FULLSCALE = 8'hC0;
  localparam logic [7:0] CMD_RD_PRESCALE  = 8'hBB;
  localparam logic [7:0] CMD_WR_PRESCALE  = 8'hBC;
  localparam logic [7:0] CMD_RD_PERIOD    = 8'hB0;
  localparam logic [7:0] CMD_RD_STATUS    = 8'hB2;
  localparam logic [7:0] CMD_WR_CONTROL   = 8'hB4;
  localparam logic [7:0] CMD_RD_CONTROL   = 8'hB3;
  // reset values and divider floor
  localparam logic [7:0] LIMIT_RST        = 8'hFF;
  localparam logic [7:0] FULLSCALE_RST    = 8'hFF;
  localparam logic [7:0] FULLSCALE_MIN    = 8'h7F;
  localparam logic [1:0] PRESCALE_RST     = 2'h1;
  // field positions
  localparam int         STATUS_FAIL_BIT  = 0;
  localparam int         CTRL_CURSENSE_BIT = 1;
  // timebase and byte width
  localparam int         REF_CLK_HZ       = 100000000;
  localparam int         TIMEBASE_HZ      = 8415;
  localparam int         TIMEBASE_DIV     = REF_CLK_HZ / TIMEBASE_HZ;
  localparam int         BYTE_BITS        = 8;

  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic       sdin;
  } spi_in_t;

  typedef struct packed {
    logic [7:0] limit;
    logic [7:0] full_scale_divider;
    logic [1:0] tach_prescale_select;
    logic       cur_sense;
  } cfg_t;
endpackage

// >>> src/fan_spi_slave.sv
`timescale 1ns/1ps
module fan_spi_slave (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  // synchronised pins
  input  wire fan_tach_pkg::spi_in_t pins,
  // read data to shift out
  input  wire logic [7:0]            rd_data,
  // decoded frame
  output logic [7:0]                 cmd_q,
  output logic                       cmd_valid,
  output logic [7:0]                 wr_data,
  output logic                       wr_strobe,
  output logic                       sdout
);
  localparam logic [4:0] CMD_LAST   = 5'(fan_tach_pkg::BYTE_BITS - 1);
  localparam logic [4:0] DATA_FIRST = 5'(fan_tach_pkg::BYTE_BITS);
  localparam logic [4:0] FRAME_LAST = 5'(2 * fan_tach_pkg::BYTE_BITS - 1);
  localparam logic [4:0] FRAME_BITS = 5'(2 * fan_tach_pkg::BYTE_BITS);

  logic       sclk_d1_q;
  logic [4:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] out_q;
  logic       rise;
  logic       fall;

  assign rise = pins.sclk & ~sclk_d1_q;
  assign fall = ~pins.sclk & sclk_d1_q;
  assign cmd_valid = (bit_cnt_q >= DATA_FIRST);
  assign sdout = out_q[7];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d1_q <= 1'b0;
    end else if (clk_en) begin
      sclk_d1_q <= pins.sclk;
    end
  end

  // command byte then one data byte per frame
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= 5'h00;
      shift_q   <= 8'h00;
      cmd_q     <= 8'h00;
      wr_data   <= 8'h00;
      wr_strobe <= 1'b0;
    end else if (clk_en) begin
      wr_strobe <= 1'b0;
      if (pins.cs_n) begin
        bit_cnt_q <= 5'h00;
      end else if (rise && bit_cnt_q != FRAME_BITS) begin
        shift_q   <= {shift_q[6:0], pins.sdin};
        bit_cnt_q <= bit_cnt_q + 5'h01;
        if (bit_cnt_q == CMD_LAST) begin
          cmd_q <= {shift_q[6:0], pins.sdin};
        end
        if (bit_cnt_q == FRAME_LAST) begin
          wr_data   <= {shift_q[6:0], pins.sdin};
          wr_strobe <= 1'b1;
        end
      end
    end
  end

  // read data shifts out on falling edges after the command byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 8'h00;
    end else if (clk_en) begin
      if (pins.cs_n) begin
        out_q <= 8'h00;
      end else if (fall && bit_cnt_q == DATA_FIRST) begin
        out_q <= rd_data;
      end else if (fall && bit_cnt_q > DATA_FIRST) begin
        out_q <= {out_q[6:0], 1'b0};
      end
    end
  end
endmodule

// >>> sim/fan_mon_props.sv
`timescale 1ns/1ps
module fan_mon_props #(
  parameter int TB_DIV = 10
) (
  // watched pins
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic tach_in,
  input wire logic current_step,
  input wire logic sdout,
  input wire logic ref_pulse,
  input wire logic speed_pulse,
  input wire logic fan_fail
);
  logic [9:0]  tach_h_q;
  logic [9:0]  cur_h_q;
  logic [7:0]  cs_h_q;
  logic [3:0]  spd_h_q;
  logic [15:0] gap_q;
  logic [15:0] quiet_q;
  logic        ref_seen_q;
  logic        spd_seen_q;
  wire         fb_edge = |(tach_h_q[8:0] & ~tach_h_q[9:1]) | |(cur_h_q[8:0] & ~cur_h_q[9:1]);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tach_h_q <= '0;
      cur_h_q <= '0;
      cs_h_q <= '0;
      spd_h_q <= '0;
    end else begin
      tach_h_q <= {tach_h_q[8:0], tach_in};
      cur_h_q <= {cur_h_q[8:0], current_step};
      cs_h_q <= {cs_h_q[6:0], !cs_n};
      spd_h_q <= {spd_h_q[2:0], speed_pulse};
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= '0;
      quiet_q <= '0;
      ref_seen_q <= 1'b0;
      spd_seen_q <= 1'b0;
    end else begin
      gap_q <= ref_pulse ? 16'h0000 : gap_q + 16'h0001;
      quiet_q <= speed_pulse ? 16'h0000 : quiet_q + {15'h0000, quiet_q != 16'hFFFF};
      ref_seen_q <= ref_seen_q | ref_pulse;
      spd_seen_q <= spd_seen_q | speed_pulse;
    end
  end
  //////////////////////////////
  AST_REF_ONE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ref_pulse |=> !ref_pulse) else $error("ref pulse too long");
  AST_REF_MIN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ref_pulse && ref_seen_q |-> int'(gap_q) >= 126 * TB_DIV - 1) else $error("ref too fast");
  AST_REF_MAX: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ref_pulse && ref_seen_q |-> int'(gap_q) <= 255 * TB_DIV) else $error("ref too slow");
  AST_SPD_ONE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    speed_pulse |=> !speed_pulse) else $error("speed pulse too long");
  AST_SPD_CAUSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    speed_pulse |-> fb_edge) else $error("speed pulse without feedback edge");
  AST_FAIL_OVF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    spd_seen_q && int'(quiet_q) >= 258 * TB_DIV |-> fan_fail) else $error("no overflow fail");
  AST_FAIL_CHG: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(fan_fail) |-> |spd_h_q || |cs_h_q || int'(quiet_q) >= 250 * TB_DIV)
    else $error("fail moved without cause");
  AST_SDOUT_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cs_n [*5] |-> !sdout) else $error("sdout busy while deselected");
endmodule

bind fan_tach_speed_monitor fan_mon_props #(.TB_DIV(TB_DIV)) i_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .tach_in(tach_in),
  .current_step(current_step), .sdout(sdout), .ref_pulse(ref_pulse),
  .speed_pulse(speed_pulse), .fan_fail(fan_fail)
);

// >>> sim/fan_model.sv
`timescale 1ns/1ps
module fan_model (
  // clock
  input  wire logic        ref_clk,
  // pulse period in cycles, zero stops the fan
  input  wire logic [15:0] period,
  input  wire logic        cur_mode,
  // fan feedback
  output logic             tach_in,
  output logic             current_step
);
  logic [15:0] cnt_q;
  wire         spin = period != 16'h0000;
  wire         hi = spin && (cnt_q < (period >> 1));
  always_ff @(posedge ref_clk) begin
    cnt_q <= (!spin || cnt_q + 16'h0001 >= period) ? 16'h0000 : cnt_q + 16'h0001;
  end
  assign tach_in = hi && !cur_mode;
  assign current_step = hi && cur_mode;
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int DIV = 10;
  logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, sclk = 1'b0, cs_n = 1'b1;
  logic sdin = 1'b0, cur_mode = 1'b0;
  logic sdout, tach_in, current_step, ref_pulse, speed_pulse, fan_fail;
  logic [15:0] period = 16'h0000;
  logic [15:0] n;
  logic [15:0] spd_cnt = 16'h0000;
  logic [15:0] s;
  logic [7:0]  rd;
  int          fail_count = 0;
  int          samples_checked = 0;
  logic [7:0]  rcmd [4] = '{8'hB1, 8'hBF, 8'hBB, 8'h00};
  logic [7:0]  rexp [4] = '{8'hFF, 8'hFF, 8'h01, 8'h00};
  fan_tach_speed_monitor #(.TB_DIV(DIV)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .sclk(sclk), .cs_n(cs_n),
    .sdin(sdin), .sdout(sdout), .tach_in(tach_in), .current_step(current_step),
    .ref_pulse(ref_pulse), .speed_pulse(speed_pulse), .fan_fail(fan_fail)
  );
  fan_model i_fan (
    .ref_clk(ref_clk), .period(period), .cur_mode(cur_mode),
    .tach_in(tach_in), .current_step(current_step)
  );
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (speed_pulse === 1'b1) spd_cnt <= spd_cnt + 16'h0001;
  end
  //////////////////////////////
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  task automatic print_verdict();
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bad(input string m);
    fail_count++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) bad($sformatf("byte %h exp %h", got, exp));
  endtask
  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
    samples_checked++;
    if (^got === 1'bx || got < lo || got > hi) bad($sformatf("count %0d", got));
  endtask
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] r);
    logic [15:0] w;
    w = {cmd, wd};
    r = '0;
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      tick(6);
      sclk <= 1'b0;
      sdin <= w[i];
      tick(6);
      if (i < 8) r[i] = sdout;
      sclk <= 1'b1;
    end
    tick(8);
    sclk <= 1'b0;
    cs_n <= 1'b1;
    tick(8);
  endtask
  task automatic wait_ref(output logic [15:0] c);
    c = '0;
    do begin
      @(posedge ref_clk);
      c++;
      if (c > 16'd3000) begin
        bad("ref timeout");
        print_verdict();
      end
    end while (ref_pulse !== 1'b1);
  endtask
  task automatic spin(input logic [15:0] per, input int k);
    period <= per;
    tick(k * per);
    period <= 16'h0000;
    tick(20);
  endtask
  //////////////////////////////
  initial begin
    tick(10);
    rst_n <= 1'b1;
    tick(6);
    foreach (rcmd[k]) begin
      xfer(rcmd[k], 8'h00, rd);
      chk8(rd, rexp[k]);
    end
    xfer(8'hB8, 8'h5A, rd);
    xfer(8'hB1, 8'h00, rd);
    chk8(rd, 8'h5A);
    $display("test registers done");
    xfer(8'hC0, 8'h10, rd);
    wait_ref(n);
    wait_ref(n);
    chk_rng(n, 127 * DIV, 127 * DIV);
    xfer(8'hC0, 8'hC8, rd);
    wait_ref(n);
    wait_ref(n);
    chk_rng(n, 200 * DIV, 200 * DIV);
    wait_ref(n);
    clk_en <= 1'b0;
    tick(500);
    clk_en <= 1'b1;
    wait_ref(n);
    chk_rng(n, 200 * DIV, 200 * DIV);
    $display("test reference done");
    for (int p = 0; p < 4; p++) begin
      xfer(8'hBC, 8'(p), rd);
      s = spd_cnt;
      spin(16'd40, 32);
      chk_rng(spd_cnt - s, 32 >> p, 32 >> p);
    end
    $display("test prescale done");
    xfer(8'hBC, 8'h00, rd);
    xfer(8'hB8, 8'h20, rd);
    spin(16'd200, 6);
    xfer(8'hB0, 8'h00, rd);
    chk_rng(16'(rd), 19, 21);
    xfer(8'hB2, 8'h00, rd);
    chk8(rd, 8'h00);
    tick(3000);
    chk8(8'(fan_fail), 8'h01);
    spin(16'd500, 6);
    xfer(8'hB0, 8'h00, rd);
    chk_rng(16'(rd), 49, 51);
    xfer(8'hB2, 8'h00, rd);
    chk8(rd, 8'h01);
    xfer(8'hB8, 8'h40, rd);
    spin(16'd500, 4);
    chk8(8'(fan_fail), 8'h00);
    $display("test failure done");
    xfer(8'hB4, 8'h02, rd);
    xfer(8'hBC, 8'h01, rd);
    xfer(8'hC0, 8'hF0, rd);
    xfer(8'hBF, 8'h00, rd);
    chk8(rd, 8'hF0);
    xfer(8'hB3, 8'h00, rd);
    chk8(rd, 8'h02);
    cur_mode <= 1'b1;
    s = spd_cnt;
    spin(16'd40, 16);
    chk_rng(spd_cnt - s, 8, 8);
    cur_mode <= 1'b0;
    s = spd_cnt;
    spin(16'd40, 16);
    chk_rng(spd_cnt - s, 0, 0);
    $display("test current sense done");
    print_verdict();
  end
endmodule
